// ===== shared/prc_pkg.sv
// Behaviour
// - both shutoff inputs off: enter power removal, cut inverter drive, no excitation
// - power removal, alarm mode 0: latched monitor on, ready outputs off, green blinks
// - power removal status reached within 15 ms of both inputs going off
// - both inputs back on: leave power removal, release cutoff, stay non-excited
// - mode 0: excitation returns only on restore input while master commands excitation
// - successful restore: monitor off, ready and brake outputs on, green steady
// - one input back on alone never releases power removal
// - feedback output on only when both inputs off
// - exactly one input off: feedback off, motor non-excited
// - restore judgment: 1 acts on rising edge, 2 on level, default 1
// - either-input-off monitor on while at least one input is off
// - mode 0: latched monitor set on any input off, cleared after restore
// - alarm mode: 0 no alarm, 1 alarm on input off, default 0
// - both-inputs-off monitor on while both inputs are off
// - mode 1: input off raises alarm 68h, red led blinks once per cycle
// - mode 1: excitation returns only on alarm-clear rising edge after release
// - brake holds during power removal, releases when excitation restored
// - alarm 53h when second input goes off later than the dual-check delay
package prc_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned MS_TIME_US = 1000;
    localparam int unsigned MS_CYCLES = MS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DEB_TIME_US = 1000;
    localparam int unsigned DEB_CYCLES = DEB_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PR_ENTRY_MAX_MS = 15;
    localparam int unsigned LED_STEP_MS = 250;
    localparam int ADDR_W = 17;
    localparam logic [15:0] IDX_ALARM_MODE = 16'h4190;
    localparam logic [15:0] IDX_DUAL_DELAY = 16'h4191;
    localparam logic [15:0] IDX_RESTORE_JUDGE = 16'h4199;
    localparam logic [15:0] IDX_STATUS = 16'h41A0;
    localparam logic [15:0] IDX_ALARM_CODE = 16'h41A1;
    localparam logic [7:0] RST_ALARM_MODE = 8'h00;
    localparam logic [7:0] RST_DUAL_DELAY = 8'h00;
    localparam logic [7:0] RST_RESTORE_JUDGE = 8'h01;
    localparam logic [7:0] MODE_NO_ALARM = 8'h00;
    localparam logic [7:0] MODE_ALARM = 8'h01;
    localparam logic [7:0] JUDGE_EDGE = 8'h01;
    localparam logic [7:0] JUDGE_LEVEL = 8'h02;
    localparam logic [7:0] DUAL_MIN_MS = 8'h0B;
    localparam logic [7:0] DUAL_MAX_MS = 8'h64;
    localparam logic [7:0] ALM_NONE = 8'h00;
    localparam logic [7:0] ALM_INPUT_OFF = 8'h68;
    localparam logic [7:0] ALM_DUAL_CHECK = 8'h53;
    localparam int ST_PR = 0;
    localparam int ST_BLOCK = 1;
    localparam int ST_EXCITE = 2;
    localparam int ST_IN_A = 3;
    localparam int ST_IN_B = 4;
    localparam int ST_ALARM = 5;
    typedef enum logic [1:0] {
        LED_GREEN_ON,
        LED_GREEN_BLINK,
        LED_RED_ONE,
        LED_RED_TWO
    } prc_led_e;
endpackage

// ===== verilog/prc_in_filter.sv
module prc_in_filter #(
    parameter int N = 4,
    parameter int unsigned DEB_CYCLES = prc_pkg::DEB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [N-1:0] raw,
    output logic [N-1:0] clean
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
        logic [31:0] cnt;
    } prc_flt_s;

    // first stage feeds only the second; agreement of stages two and three counts
    for (genvar i = 0; i < N; i++) begin : g_bit
        prc_flt_s q, d;
        always_comb begin
            d = q;
            d.s1 = raw[i];
            d.s2 = q.s1;
            d.s3 = q.s2;
            if (q.s2 == q.s3 && q.s3 != q.out) begin
                if (q.cnt >= 32'(DEB_CYCLES - 1)) begin
                    d.out = q.s3;
                    d.cnt = 32'h0000_0000;
                end else begin
                    d.cnt = q.cnt + 32'h0000_0001;
                end
            end else begin
                d.cnt = 32'h0000_0000;
            end
        end
        // inputs start as off so a fresh start always waits for a restore
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                q <= '0;
            end else begin
                q <= d;
            end
        end
        assign clean[i] = q.out;
    end
endmodule // prc_in_filter

// ===== verilog/prc_led.sv
module prc_led (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ms_tick,
    input wire prc_pkg::prc_led_e pattern,
    output logic led_green,
    output logic led_red
);
    typedef struct packed {
        logic [15:0] step;
        logic [2:0] phase;
        logic green;
        logic red;
    } prc_led_s;

    prc_led_s q, d;

    always_comb begin
        d = q;
        if (ms_tick) begin
            if (q.step >= 16'(prc_pkg::LED_STEP_MS - 1)) begin
                d.step = 16'h0000;
                d.phase = q.phase + 3'h1;
            end else begin
                d.step = q.step + 16'h0001;
            end
        end
        case (pattern)
            prc_pkg::LED_GREEN_ON: begin
                d.green = 1'b1;
                d.red = 1'b0;
            end
            prc_pkg::LED_GREEN_BLINK: begin
                d.green = ~q.phase[0];
                d.red = 1'b0;
            end
            prc_pkg::LED_RED_ONE: begin
                d.green = 1'b0;
                d.red = (q.phase == 3'h0);
            end
            prc_pkg::LED_RED_TWO: begin
                d.green = 1'b0;
                d.red = (q.phase == 3'h0) || (q.phase == 3'h2);
            end
            default: begin
                d.green = 1'b0;
                d.red = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign led_green = q.green;
    assign led_red = q.red;
endmodule // prc_led

// ===== verilog/prc_power_removal.sv
module prc_power_removal #(
    parameter int unsigned MS_CYCLES = prc_pkg::MS_CYCLES,
    parameter int unsigned DEB_CYCLES = prc_pkg::DEB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,

    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    input wire logic shutoff_in_a,
    input wire logic shutoff_in_b,
    input wire logic excitation_restore_in,
    input wire logic alarm_clear_in,
    input wire logic excitation_cmd_in,

    output logic inverter_drive_enable,
    output logic motor_excite_out,
    output logic shutoff_feedback_out,
    output logic shutoff_latched_monitor,
    output logic command_ready_out,
    output logic ready_out,
    output logic pulse_ready_out,
    output logic brake_control_out,
    output logic either_input_off_monitor,
    output logic both_inputs_off_monitor,

    output logic power_alarm_led_green,
    output logic power_alarm_led_red,
    output logic alarm_active_out,
    output logic [7:0] alarm_code_out
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] judge;
        logic [7:0] dual;

        logic [31:0] prdata;
        logic pready;
        logic pslverr;

        logic [31:0] ms_cnt;
        logic ms_tick;
        logic [7:0] dual_ms;

        logic pr_status;
        logic block;
        logic [7:0] alarm;
        logic restore_prev;
        logic clear_prev;

        logic inv_en;
        logic excite;
        logic feedback;
        logic latched;
        logic rdy;
        logic cmd_ready;
        logic pulse_ready;
        logic brake;
        logic alm_act;
        logic any_off;
        logic both_off;
        prc_pkg::prc_led_e led_pat;
    } prc_top_s;

    prc_top_s q, d;
    logic [3:0] clean;
    logic in_a_on;
    logic in_b_on;
    logic restore_on;
    logic clear_on;

    // all four pins pass the same filter, so none outruns another
    prc_in_filter #(
        .N(4),
        .DEB_CYCLES(DEB_CYCLES)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst(rst),
        .raw({alarm_clear_in, excitation_restore_in, shutoff_in_b, shutoff_in_a}),
        .clean(clean)
    );

    assign in_a_on = clean[0];
    assign in_b_on = clean[1];
    assign restore_on = clean[2];
    assign clear_on = clean[3];

    prc_led u_led (
        .ref_clk(ref_clk),
        .rst(rst),
        .ms_tick(q.ms_tick),
        .pattern(q.led_pat),
        .led_green(power_alarm_led_green),
        .led_red(power_alarm_led_red)
    );

    always_comb begin
        logic sel_mode;
        logic sel_dual;
        logic sel_judge;
        logic sel_status;
        logic sel_alarm;
        logic aligned;
        logic wr_ok;
        logic [7:0] wbyte;
        logic both_on;
        logic any_off;
        logic both_off;
        logic one_off;
        logic restore_hit;
        logic clear_rise;
        logic ready;
        logic [31:0] status;

        sel_mode = 1'b0;
        sel_dual = 1'b0;
        sel_judge = 1'b0;
        sel_status = 1'b0;
        sel_alarm = 1'b0;
        aligned = 1'b0;
        wr_ok = 1'b0;
        wbyte = 8'h00;
        both_on = 1'b0;
        any_off = 1'b0;
        both_off = 1'b0;
        one_off = 1'b0;
        restore_hit = 1'b0;
        clear_rise = 1'b0;
        ready = 1'b0;
        status = 32'h0000_0000;
        d = q;

        // millisecond time base for the dual-check timer and the led
        // one shared tick keeps the led and the dual timer in step
        d.ms_tick = 1'b0;
        if (q.ms_cnt >= 32'(MS_CYCLES - 1)) begin
            d.ms_cnt = 32'h0000_0000;
            d.ms_tick = 1'b1;
        end else begin
            d.ms_cnt = q.ms_cnt + 32'h0000_0001;
        end

        // input combinations
        both_on = in_a_on && in_b_on;
        both_off = !in_a_on && !in_b_on;
        any_off = !both_on;
        one_off = any_off && !both_off;
        d.any_off = any_off;
        d.both_off = both_off;
        d.feedback = both_off;

        // power removal status follows the pair, never a single input
        if (both_off) begin
            d.pr_status = 1'b1;
        end else if (both_on) begin
            d.pr_status = 1'b0;
        end
        // inverter drive is cut while in power removal status
        d.inv_en = !d.pr_status;

        // restore input detection
        d.restore_prev = restore_on;
        d.clear_prev = clear_on;
        clear_rise = clear_on && !q.clear_prev;
        if (q.judge == prc_pkg::JUDGE_LEVEL) begin
            restore_hit = restore_on;
        end else begin
            restore_hit = restore_on && !q.restore_prev;
        end

        // block latch: any input off holds off excitation until a restore
        // in mode 1 the restore input is ignored; only the clear edge re-arms
        if (any_off) begin
            d.block = 1'b1;
        end else if (q.mode == prc_pkg::MODE_ALARM) begin
            if (clear_rise && !q.pr_status) begin
                d.block = 1'b0;
            end
        end else if (!q.pr_status && q.alarm == prc_pkg::ALM_NONE) begin
            if (restore_hit && excitation_cmd_in) begin
                d.block = 1'b0;
            end
        end

        // dual-check timer runs only while exactly one input is off
        // it saturates so a long single-off spell never wraps back to zero
        if (one_off) begin
            if (q.ms_tick && q.dual_ms != 8'hFF) begin
                d.dual_ms = q.dual_ms + 8'h01;
            end
        end else begin
            d.dual_ms = 8'h00;
        end

        // alarms: the setting event wins over a clear in the same cycle
        if (one_off && q.dual >= prc_pkg::DUAL_MIN_MS && q.dual_ms > q.dual) begin
            d.alarm = prc_pkg::ALM_DUAL_CHECK;
        end else if (any_off && q.mode == prc_pkg::MODE_ALARM) begin
            if (q.alarm == prc_pkg::ALM_NONE) begin
                d.alarm = prc_pkg::ALM_INPUT_OFF;
            end
        end else if (both_on && clear_rise && !q.pr_status) begin
            d.alarm = prc_pkg::ALM_NONE;
        end

        // output levels, all registered
        ready = !d.block && both_on && d.alarm == prc_pkg::ALM_NONE;
        // one flop per pin, so no output is a fan-out of another
        d.rdy = ready;
        d.cmd_ready = ready;
        d.pulse_ready = ready;
        // brake released only with excitation ready; held otherwise
        d.brake = ready;
        // the alarm pin gets its own flop rather than a decode of the code
        d.alm_act = d.alarm != prc_pkg::ALM_NONE;
        // the command is same-clock logic and needs no pin filter
        d.excite = ready && excitation_cmd_in;
        d.latched = d.block && q.mode == prc_pkg::MODE_NO_ALARM;

        // led pattern, alarms first
        if (d.alarm == prc_pkg::ALM_DUAL_CHECK) begin
            d.led_pat = prc_pkg::LED_RED_TWO;
        end else if (d.alarm == prc_pkg::ALM_INPUT_OFF) begin
            d.led_pat = prc_pkg::LED_RED_ONE;
        end else if (d.pr_status && q.mode == prc_pkg::MODE_NO_ALARM) begin
            d.led_pat = prc_pkg::LED_GREEN_BLINK;
        end else begin
            d.led_pat = prc_pkg::LED_GREEN_ON;
        end

        // status word
        // inputs shown are the filtered levels that the logic acts on
        status[prc_pkg::ST_PR] = q.pr_status;
        status[prc_pkg::ST_BLOCK] = q.block;
        status[prc_pkg::ST_EXCITE] = q.excite;
        status[prc_pkg::ST_IN_A] = in_a_on;
        status[prc_pkg::ST_IN_B] = in_b_on;
        status[prc_pkg::ST_ALARM] = (q.alarm != prc_pkg::ALM_NONE);

        // register decode, word index is the byte address over four
        aligned = (paddr[1:0] == 2'h0);
        sel_mode = aligned && {1'b0, paddr[16:2]} == prc_pkg::IDX_ALARM_MODE;
        sel_dual = aligned && {1'b0, paddr[16:2]} == prc_pkg::IDX_DUAL_DELAY;
        sel_judge = aligned && {1'b0, paddr[16:2]} == prc_pkg::IDX_RESTORE_JUDGE;
        sel_status = aligned && {1'b0, paddr[16:2]} == prc_pkg::IDX_STATUS;
        sel_alarm = aligned && {1'b0, paddr[16:2]} == prc_pkg::IDX_ALARM_CODE;

        wbyte = pwdata[7:0];
        // out-of-range settings are refused rather than clipped
        if (sel_mode) begin
            wr_ok = (pwdata[31:8] == 24'h000000) && wbyte <= prc_pkg::MODE_ALARM;
        end else if (sel_judge) begin
            wr_ok = (pwdata[31:8] == 24'h000000)
                && (wbyte == prc_pkg::JUDGE_EDGE || wbyte == prc_pkg::JUDGE_LEVEL);
        end else if (sel_dual) begin
            wr_ok = (pwdata[31:8] == 24'h000000) && wbyte <= prc_pkg::DUAL_MAX_MS;
        end

        // setup cycle prepares the answer; the access edge commits it
        // pready rises one cycle after setup and stands exactly one cycle
        if (psel && !penable && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            d.pslverr = 1'b0;
            if (pwrite) begin
                d.pslverr = !wr_ok;
            end else if (sel_mode) begin
                d.prdata = {24'h000000, q.mode};
            end else if (sel_dual) begin
                d.prdata = {24'h000000, q.dual};
            end else if (sel_judge) begin
                d.prdata = {24'h000000, q.judge};
            end else if (sel_status) begin
                d.prdata = status;
            end else if (sel_alarm) begin
                d.prdata = {24'h000000, q.alarm};
            end else begin
                d.pslverr = 1'b1;
            end
        end else if (psel && penable && q.pready) begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
            // a write refused in setup leaves every setting untouched
            if (pwrite && !q.pslverr) begin
                if (sel_mode) begin
                    d.mode = wbyte;
                end else if (sel_dual) begin
                    d.dual = wbyte;
                end else if (sel_judge) begin
                    d.judge = wbyte;
                end
            end
        end else begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.mode <= prc_pkg::RST_ALARM_MODE;
            q.judge <= prc_pkg::RST_RESTORE_JUDGE;
            q.dual <= prc_pkg::RST_DUAL_DELAY;
            // the block starts latched, so power-up always needs a restore
            q.pr_status <= 1'b1;
            q.block <= 1'b1;
            q.any_off <= 1'b1;
            q.both_off <= 1'b1;
            q.feedback <= 1'b1;
            q.latched <= 1'b1;
            q.alarm <= prc_pkg::ALM_NONE;
            q.led_pat <= prc_pkg::LED_GREEN_BLINK;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    assign inverter_drive_enable = q.inv_en;
    assign motor_excite_out = q.excite;
    assign shutoff_feedback_out = q.feedback;
    assign shutoff_latched_monitor = q.latched;
    assign command_ready_out = q.cmd_ready;
    assign ready_out = q.rdy;
    assign pulse_ready_out = q.pulse_ready;
    assign brake_control_out = q.brake;
    assign either_input_off_monitor = q.any_off;
    assign both_inputs_off_monitor = q.both_off;
    assign alarm_active_out = q.alm_act;
    assign alarm_code_out = q.alarm;
endmodule // prc_power_removal

// ===== verif/prc_power_removal_asserts.sv
module prc_power_removal_asserts #(
    parameter int unsigned DEB_CYCLES = prc_pkg::DEB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic shutoff_in_a,
    input wire logic shutoff_in_b,
    input wire logic inverter_drive_enable,
    input wire logic motor_excite_out,
    input wire logic shutoff_feedback_out,
    input wire logic shutoff_latched_monitor,
    input wire logic command_ready_out,
    input wire logic ready_out,
    input wire logic pulse_ready_out,
    input wire logic brake_control_out,
    input wire logic either_input_off_monitor,
    input wire logic both_inputs_off_monitor,
    input wire logic alarm_active_out,
    input wire logic [7:0] alarm_code_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // margin covers three sync flops, the debounce run and two output stages
    localparam int SETTLE = DEB_CYCLES + 10;
    logic [7:0] off_cnt_q;
    logic [7:0] one_cnt_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            off_cnt_q <= 8'h00;
            one_cnt_q <= 8'h00;
        end else begin
            off_cnt_q <= (shutoff_in_a || shutoff_in_b) ? 8'h00 : off_cnt_q + 8'(off_cnt_q != 8'hFF);
            one_cnt_q <= (shutoff_in_a ^ shutoff_in_b) ? one_cnt_q + 8'(one_cnt_q != 8'hFF) : 8'h00;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    removal_entry_a: assert property (off_cnt_q > SETTLE |->
        shutoff_feedback_out && both_inputs_off_monitor && !inverter_drive_enable && !ready_out)
        else $error("power removal not reached with both inputs off");
    one_off_a: assert property (one_cnt_q > SETTLE |->
        !shutoff_feedback_out && either_input_off_monitor && !both_inputs_off_monitor && !motor_excite_out)
        else $error("single input off handled wrongly");
    feedback_pair_a: assert property (shutoff_feedback_out == both_inputs_off_monitor)
        else $error("feedback differs from both-off monitor");
    ready_group_a: assert property (command_ready_out == ready_out && pulse_ready_out == ready_out
        && brake_control_out == ready_out)
        else $error("ready outputs disagree");
    restore_clears_a: assert property ($rose(ready_out) |->
        !shutoff_latched_monitor && !either_input_off_monitor)
        else $error("ready rose while latched or an input off");
    off_drops_ready_a: assert property ($rose(either_input_off_monitor) |-> ##[0:2] !ready_out)
        else $error("ready kept after an input went off");
    excite_needs_ready_a: assert property ($rose(motor_excite_out) |-> ready_out)
        else $error("motor excited without ready");
    alarm_flag_a: assert property (alarm_active_out == (alarm_code_out != 8'h00))
        else $error("alarm flag and code disagree");
endmodule // prc_power_removal_asserts

// ===== verif/prc_partner.sv
module prc_partner #(
    parameter int unsigned HOLD = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic want_a,
    input wire logic want_b,
    input wire logic feedback,
    output logic pin_a,
    output logic pin_b
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned held = 0;
    always @(posedge ref_clk) begin
        if (rst) begin
            pin_a <= 1'b1;
            pin_b <= 1'b1;
            held <= 0;
        end else if (held < HOLD) begin
            held <= held + 1;
        end else if ({want_a, want_b} != {pin_a, pin_b} && (pin_a || pin_b || feedback)) begin
            pin_a <= want_a;
            pin_b <= want_b;
            held <= 0;
        end
    end
endmodule // prc_partner

// ===== verif/prc_power_removal_tb.sv
module prc_power_removal_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MSC = 20;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic want_a = 1'b1, want_b = 1'b1, rsto = 1'b0, clr = 1'b0, cmd = 1'b0, err, g;
    logic [16:0] paddr = 17'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, pin_a, pin_b, inv_en, excite, fb, latched, cmd_rdy, rdy, pulse_rdy, brake;
    logic either_off, both_off, led_g, led_r, alm;
    logic [7:0] code;
    int miscompares = 0, n_tests = 0, cyc = 0, n;
    prc_power_removal #(.MS_CYCLES(MSC), .DEB_CYCLES(4)) i_prc_power_removal (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shutoff_in_a(pin_a), .shutoff_in_b(pin_b), .excitation_restore_in(rsto),
        .alarm_clear_in(clr), .excitation_cmd_in(cmd), .inverter_drive_enable(inv_en),
        .motor_excite_out(excite), .shutoff_feedback_out(fb), .shutoff_latched_monitor(latched),
        .command_ready_out(cmd_rdy), .ready_out(rdy), .pulse_ready_out(pulse_rdy),
        .brake_control_out(brake), .either_input_off_monitor(either_off),
        .both_inputs_off_monitor(both_off), .power_alarm_led_green(led_g),
        .power_alarm_led_red(led_r), .alarm_active_out(alm), .alarm_code_out(code));
    prc_partner #(.HOLD(12)) i_prc_partner (.ref_clk(ref_clk), .rst(rst), .want_a(want_a),
        .want_b(want_b), .feedback(fb), .pin_a(pin_a), .pin_b(pin_b));
    always #2.5 ref_clk = ~ref_clk;
    task automatic close_out();
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
        n_tests++;
        if (x !== got) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, x, got);
        end
    endtask
    function automatic logic [4:0] expect_outs(input logic a, input logic b, input logic r, input logic m);
        return {!a && !b, !r && !m, r, !a || !b, !a && !b};
    endfunction
    task automatic outs(input logic a, input logic b, input logic r, input logic m);
        chk("outputs", {27'h0, expect_outs(a, b, r, m)}, {27'h0, fb, latched, rdy, either_off, both_off});
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // the idle cycle after each transfer keeps a strobe from being driven twice in one step
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx[14:0], 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic e);
        apb(1'b1, idx, d);
        chk("pslverr", {31'h0, e}, {31'h0, err});
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [31:0] x, input logic e);
        apb(1'b0, idx, 32'h0);
        chk("pslverr", {31'h0, e}, {31'h0, err});
        chk("prdata", x, rd);
    endtask
    task automatic settle();
        wt(40 + $urandom_range(0, 20));
    endtask
    task automatic pulse(input bit c);
        if (c) clr <= 1'b1;
        else rsto <= 1'b1;
        wt(12);
        clr <= 1'b0;
        rsto <= 1'b0;
        wt(12);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        void'($urandom(32'h7B046DC4));
        wt(8);
        rst <= 1'b0;
        wt(1);
        outs(0, 0, 0, 0);
        rdc(16'h4190, 32'h0, 1'b0);
        rdc(16'h4199, 32'h1, 1'b0);
        rdc(16'h4180, 32'h0, 1'b1);
        wr(16'h41A0, 32'h1, 1'b1);
        wr(16'h4190, $urandom_range(2, 255), 1'b1);
        wr(16'h4199, $urandom_range(3, 255), 1'b1);
        wr(16'h4191, $urandom_range(101, 255), 1'b1);
        rdc(16'h4190, 32'h0, 1'b0);
        done("registers");
        settle();
        outs(1, 1, 0, 0);
        chk("drive", 32'h1, {31'h0, inv_en});
        pulse(0);
        outs(1, 1, 0, 0);
        cmd <= 1'b1;
        pulse(0);
        outs(1, 1, 1, 0);
        chk("excite", 32'h1, {31'h0, excite});
        chk("green", 32'h1, {31'h0, led_g});
        chk("red", 32'h0, {31'h0, led_r});
        done("restore");
        want_a <= 1'b0;
        settle();
        outs(0, 1, 0, 0);
        chk("excite", 32'h0, {31'h0, excite});
        want_b <= 1'b0;
        settle();
        outs(0, 0, 0, 0);
        chk("drive", 32'h0, {31'h0, inv_en});
        g = led_g;
        n = 0;
        while (led_g === g && n < 12000) begin
            n++;
            @(posedge ref_clk);
        end
        chk("blink", 32'h1, {31'h0, n < 12000});
        rsto <= 1'b1;
        want_a <= 1'b1;
        settle();
        outs(1, 0, 0, 0);
        chk("drive", 32'h0, {31'h0, inv_en});
        want_b <= 1'b1;
        settle();
        outs(1, 1, 0, 0);
        chk("drive", 32'h1, {31'h0, inv_en});
        wr(16'h4199, 32'h2, 1'b0);
        wt(6);
        outs(1, 1, 1, 0);
        rsto <= 1'b0;
        done("shutoff");
        wr(16'h4190, 32'h1, 1'b0);
        wr(16'h4199, 32'h1, 1'b0);
        want_b <= 1'b0;
        settle();
        outs(1, 0, 0, 1);
        chk("alarm", 32'h68, {24'h0, code});
        chk("green", 32'h0, {31'h0, led_g});
        rdc(16'h41A1, 32'h68, 1'b0);
        rdc(16'h41A0, 32'h2A, 1'b0);
        want_b <= 1'b1;
        settle();
        pulse(0);
        outs(1, 1, 0, 1);
        pulse(1);
        outs(1, 1, 1, 1);
        chk("alarm", 32'h0, {24'h0, code});
        done("alarm");
        wr(16'h4191, 32'h0B, 1'b0);
        want_a <= 1'b0;
        wt(11 * MSC + 80);
        chk("alarm", 32'h53, {24'h0, code});
        want_a <= 1'b1;
        settle();
        pulse(1);
        chk("alarm", 32'h0, {24'h0, code});
        done("dual");
        close_out();
    end
endmodule // prc_power_removal_tb
bind prc_power_removal prc_power_removal_asserts #(.DEB_CYCLES(DEB_CYCLES)) i_prc_power_removal_asserts (
    .ref_clk(ref_clk), .rst(rst), .shutoff_in_a(shutoff_in_a), .shutoff_in_b(shutoff_in_b),
    .inverter_drive_enable(inverter_drive_enable), .motor_excite_out(motor_excite_out),
    .shutoff_feedback_out(shutoff_feedback_out), .shutoff_latched_monitor(shutoff_latched_monitor),
    .command_ready_out(command_ready_out), .ready_out(ready_out), .pulse_ready_out(pulse_ready_out),
    .brake_control_out(brake_control_out), .either_input_off_monitor(either_input_off_monitor),
    .both_inputs_off_monitor(both_inputs_off_monitor), .alarm_active_out(alarm_active_out),
    .alarm_code_out(alarm_code_out));
